//--- rtl/gp_timer_pkg.sv
// Package for the general purpose timer set: offsets, fields, reset values
package gp_timer_pkg;
    localparam logic [3:0] ADDR_SINGLE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_SINGLE_COUNT = 4'h1;
    localparam logic [3:0] ADDR_SINGLE_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_LOW_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_HIGH_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_LOW_COUNT = 4'h5;
    localparam logic [3:0] ADDR_HIGH_COUNT = 4'h6;
    localparam logic [3:0] ADDR_LOW_PERIOD = 4'h7;
    localparam logic [3:0] ADDR_HIGH_PERIOD = 4'h8;
    localparam logic [3:0] ADDR_FLAGS = 4'h9;
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_JOIN = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CLK_SRC = 1;
    localparam logic [15:0] SINGLE_CONTROL_MASK = 16'ha076;
    localparam logic [15:0] LOW_CONTROL_MASK = 16'ha07a;
    localparam logic [15:0] HIGH_CONTROL_MASK = 16'ha072;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [7:0] PS_DIV_1 = 8'h00;
    localparam logic [7:0] PS_DIV_8 = 8'h07;
    localparam logic [7:0] PS_DIV_64 = 8'h3f;
    localparam logic [7:0] PS_DIV_256 = 8'hff;
endpackage : gp_timer_pkg

//--- rtl/gp_timer_set.sv
// General purpose timer set: one single timer and one pairable timer pair
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
// Function
// (R1) Single 16-bit timer, sync or async counter
// (R2) Flag on period match or gate fall
// (R3) Bit 15 starts and stops counting
// (R4) Bit 13 halts timer in idle
// (R5) Gate bit only with internal clock
// (R6) Prescale bits 5:4 divide 1/8/64/256
// (R7) Bit 2 syncs external clock
// (R8) Bit 1 picks pin rising edge
// (R9) Unimplemented control bits read zero
// (R10) Pair timers alone are synchronous only
// (R11) Joined pair: 32-bit count and match
// (R12) High count holds upper word
// (R13) High period holds upper word
// (R14) Joined: high control bits ignored
// (R15) Joined match sets high timer flag
// (R16) Software sets join for 32-bit use
// (R17) Software sets run bit last
// (R18) Pair gives converter event trigger
// (R19) Pair timers request data transfers
// (R20) Pair timers serve as capture timebases
// (R21) Bit 3 of low control joins pair
// (R22) Match clears count and sets flag
module gp_timer_set
    import gp_timer_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic SRST_IN,
    // Register port
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    // Device state and pins
    input wire logic IDLE_IN,
    input wire logic SINGLE_TIMER_EXT_CLOCK_PIN_IN,
    input wire logic PAIR_EXT_CLOCK_PIN_IN,
    input wire logic HIGH_EXT_CLOCK_PIN_IN,
    // Events
    output logic SINGLE_TIMER_IRQ_FLAG_OUT,
    output logic LOW_TIMER_IRQ_FLAG_OUT,
    output logic HIGH_TIMER_IRQ_FLAG_OUT,
    output logic ADC_TRIGGER_OUT,
    output logic LOW_DMA_REQ_OUT,
    output logic HIGH_DMA_REQ_OUT,
    output logic [15:0] TIMEBASE_LOW_OUT,
    output logic [15:0] TIMEBASE_HIGH_OUT
);
    logic [15:0] ctl_reg [3];
    logic [15:0] cnt_reg [3];
    logic [15:0] per_reg [3];
    logic [2:0] pin_q_reg;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] pin_sync_d_reg;
    logic [7:0] ps_reg [3];
    logic [2:0] flag_reg;
    logic [2:0] flag_set;
    logic [2:0] tick;
    logic [2:0] match;
    logic joined;
    logic [31:0] count32;
    logic [31:0] period32;
    logic gate_fall;
    logic [15:0] rdata_next;

    assign joined = ctl_reg[1][BIT_JOIN]; // see (R21)
    assign count32 = {cnt_reg[2], cnt_reg[1]}; // see (R12)
    assign period32 = {per_reg[2], per_reg[1]}; // see (R13)

    // Pin synchronisers and edge history
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            pin_q_reg <= 3'h0;
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            pin_sync_d_reg <= 3'h0;
        end else begin
            pin_q_reg <= {HIGH_EXT_CLOCK_PIN_IN, PAIR_EXT_CLOCK_PIN_IN,
                SINGLE_TIMER_EXT_CLOCK_PIN_IN};
            pin_meta_reg <= {HIGH_EXT_CLOCK_PIN_IN, PAIR_EXT_CLOCK_PIN_IN,
                SINGLE_TIMER_EXT_CLOCK_PIN_IN};
            pin_sync_reg <= pin_meta_reg;
            pin_sync_d_reg <= pin_sync_reg;
        end
    end

    // Single timer gate falls while gated accumulation is active
    assign gate_fall = ctl_reg[0][BIT_GATE] && !ctl_reg[0][BIT_CLK_SRC]
        && ctl_reg[0][BIT_RUN] && pin_sync_d_reg[0] && !pin_sync_reg[0]; // see (R2) (R5)

    // Per timer prescaled tick
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_tick
            logic [15:0] c;
            logic raw;
            logic ext_edge;
            logic [7:0] div;
            assign c = (g == 2 && joined) ? ctl_reg[1] : ctl_reg[g]; // see (R14)
            // Async-style counting samples the raw pin edge, skipping the extra stage
            assign ext_edge = (g == 0 && !c[BIT_SYNC])
                ? (pin_q_reg[0] && !pin_sync_reg[0])
                : (pin_sync_reg[g] && !pin_sync_d_reg[g]); // see (R7) (R10)
            always_comb begin
                case (c[BIT_PS_HI:BIT_PS_LO]) // see (R6)
                    2'b11: div = PS_DIV_256;
                    2'b10: div = PS_DIV_64;
                    2'b01: div = PS_DIV_8;
                    default: div = PS_DIV_1;
                endcase
                if (c[BIT_CLK_SRC]) begin
                    raw = ext_edge; // see (R8) (R1)
                end else if (c[BIT_GATE]) begin
                    raw = pin_sync_reg[(g == 2 && joined) ? 1 : g]; // see (R5)
                end else begin
                    raw = 1'b1;
                end
                if (!c[BIT_RUN] || (IDLE_IN && c[BIT_IDLE_STOP])) begin
                    raw = 1'b0; // see (R3) (R4)
                end
            end
            always_ff @(posedge CLOCK_IN) begin
                if (SRST_IN || !c[BIT_RUN]) begin
                    ps_reg[g] <= 8'h00;
                end else if (raw) begin
                    ps_reg[g] <= (ps_reg[g] >= div) ? 8'h00 : ps_reg[g] + 8'h01;
                end
            end
            assign tick[g] = raw && (ps_reg[g] >= div);
        end
    endgenerate

    assign match[0] = cnt_reg[0] == per_reg[0];
    assign match[1] = joined ? (count32 == period32) : (cnt_reg[1] == per_reg[1]); // see (R11)
    assign match[2] = cnt_reg[2] == per_reg[2];

    // Flag causes; in joined mode the high timer flag takes the match
    always_comb begin
        flag_set[0] = (tick[0] && match[0]) || gate_fall; // see (R2) (R22)
        flag_set[1] = !joined && tick[1] && match[1];
        flag_set[2] = joined ? (tick[1] && match[1]) : (tick[2] && match[2]); // see (R15)
    end

    // Count registers and software writes
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            for (int i = 0; i < 3; i++) begin
                cnt_reg[i] <= 16'h0000;
            end
        end else begin
            if (tick[0]) begin
                cnt_reg[0] <= match[0] ? 16'h0000 : cnt_reg[0] + 16'h0001; // see (R22)
            end
            if (joined) begin
                if (tick[1]) begin
                    {cnt_reg[2], cnt_reg[1]} <= match[1] ? 32'h0 : count32 + 32'h1; // see (R11)
                end
            end else begin
                for (int i = 1; i < 3; i++) begin
                    if (tick[i]) begin
                        cnt_reg[i] <= match[i] ? 16'h0000 : cnt_reg[i] + 16'h0001;
                    end
                end
            end
            if (WR_IN && ADDR_IN == ADDR_SINGLE_COUNT) begin
                cnt_reg[0] <= WDATA_IN;
            end
            if (WR_IN && ADDR_IN == ADDR_LOW_COUNT) begin
                cnt_reg[1] <= WDATA_IN;
            end
            if (WR_IN && ADDR_IN == ADDR_HIGH_COUNT) begin
                cnt_reg[2] <= WDATA_IN;
            end
        end
    end

    // Control and period registers
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            for (int i = 0; i < 3; i++) begin
                ctl_reg[i] <= CONTROL_RESET;
                per_reg[i] <= PERIOD_RESET;
            end
        end else if (WR_IN) begin
            case (ADDR_IN)
                ADDR_SINGLE_CONTROL: ctl_reg[0] <= WDATA_IN & SINGLE_CONTROL_MASK; // see (R9)
                ADDR_LOW_CONTROL: ctl_reg[1] <= WDATA_IN & LOW_CONTROL_MASK;
                ADDR_HIGH_CONTROL: ctl_reg[2] <= WDATA_IN & HIGH_CONTROL_MASK;
                ADDR_SINGLE_PERIOD: per_reg[0] <= WDATA_IN;
                ADDR_LOW_PERIOD: per_reg[1] <= WDATA_IN;
                ADDR_HIGH_PERIOD: per_reg[2] <= WDATA_IN;
                default: ;
            endcase
        end
    end

    // Sticky event flags; writing one clears, a new event wins
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            flag_reg <= 3'h0;
        end else if (WR_IN && ADDR_IN == ADDR_FLAGS) begin
            flag_reg <= (flag_reg & ~WDATA_IN[2:0]) | flag_set;
        end else begin
            flag_reg <= flag_reg | flag_set;
        end
    end

    always_comb begin
        case (ADDR_IN)
            ADDR_SINGLE_CONTROL: rdata_next = ctl_reg[0]; // see (R9)
            ADDR_SINGLE_COUNT: rdata_next = cnt_reg[0];
            ADDR_SINGLE_PERIOD: rdata_next = per_reg[0];
            ADDR_LOW_CONTROL: rdata_next = ctl_reg[1];
            ADDR_HIGH_CONTROL: rdata_next = ctl_reg[2];
            ADDR_LOW_COUNT: rdata_next = cnt_reg[1];
            ADDR_HIGH_COUNT: rdata_next = cnt_reg[2];
            ADDR_LOW_PERIOD: rdata_next = per_reg[1];
            ADDR_HIGH_PERIOD: rdata_next = per_reg[2];
            ADDR_FLAGS: rdata_next = {13'h0000, flag_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // Registered outputs
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= 16'h0000;
            SINGLE_TIMER_IRQ_FLAG_OUT <= 1'b0;
            LOW_TIMER_IRQ_FLAG_OUT <= 1'b0;
            HIGH_TIMER_IRQ_FLAG_OUT <= 1'b0;
            ADC_TRIGGER_OUT <= 1'b0;
            LOW_DMA_REQ_OUT <= 1'b0;
            HIGH_DMA_REQ_OUT <= 1'b0;
            TIMEBASE_LOW_OUT <= 16'h0000;
            TIMEBASE_HIGH_OUT <= 16'h0000;
        end else begin
            RDATA_OUT <= RD_IN ? rdata_next : 16'h0000;
            SINGLE_TIMER_IRQ_FLAG_OUT <= flag_reg[0] | flag_set[0];
            LOW_TIMER_IRQ_FLAG_OUT <= flag_reg[1] | flag_set[1];
            HIGH_TIMER_IRQ_FLAG_OUT <= flag_reg[2] | flag_set[2];
            ADC_TRIGGER_OUT <= flag_set[2]; // see (R18)
            LOW_DMA_REQ_OUT <= flag_set[1]; // see (R19)
            HIGH_DMA_REQ_OUT <= flag_set[2]; // see (R19)
            TIMEBASE_LOW_OUT <= cnt_reg[1]; // see (R20)
            TIMEBASE_HIGH_OUT <= cnt_reg[2]; // see (R20)
        end
    end
endmodule : gp_timer_set

//--- verification/gp_timer_chk.sv
// Port checker for the general purpose timer set
`timescale 1ns/1ns
module gp_timer_chk
    import gp_timer_pkg::*;
(
    // Clock, reset and register port
    input wire logic CLOCK_IN,
    input wire logic SRST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [15:0] RDATA_OUT,
    // Events
    input wire logic SINGLE_TIMER_IRQ_FLAG_OUT,
    input wire logic HIGH_TIMER_IRQ_FLAG_OUT,
    input wire logic LOW_TIMER_IRQ_FLAG_OUT,
    input wire logic ADC_TRIGGER_OUT,
    input wire logic LOW_DMA_REQ_OUT,
    input wire logic [15:0] TIMEBASE_LOW_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);
    logic clr;
    logic wlo;
    assign clr = WR_IN && ADDR_IN == ADDR_FLAGS && WDATA_IN[0];
    assign wlo = WR_IN && ADDR_IN == ADDR_LOW_COUNT;
    property p_rd_idle; !$past(RD_IN) |-> RDATA_OUT == 16'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_ctl1;
        $past(RD_IN) && $past(ADDR_IN) == ADDR_SINGLE_CONTROL |->
            (RDATA_OUT & ~SINGLE_CONTROL_MASK) == 16'h0;
    endproperty
    a_ctl1: assert property (p_ctl1) else $error("single control bits");
    property p_ctl2;
        $past(RD_IN) && $past(ADDR_IN) == ADDR_LOW_CONTROL |->
            (RDATA_OUT & ~LOW_CONTROL_MASK) == 16'h0;
    endproperty
    a_ctl2: assert property (p_ctl2) else $error("low control bits");
    property p_unmap; $past(RD_IN) && $past(ADDR_IN) > ADDR_FLAGS |-> RDATA_OUT == 16'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold;
        !clr ##1 (SINGLE_TIMER_IRQ_FLAG_OUT && !clr) ##1 !clr |=> SINGLE_TIMER_IRQ_FLAG_OUT;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_adc; ADC_TRIGGER_OUT |-> ##[0:1] HIGH_TIMER_IRQ_FLAG_OUT; endproperty
    a_adc: assert property (p_adc) else $error("trigger without flag");
    property p_dma; LOW_DMA_REQ_OUT |-> ##[0:1] LOW_TIMER_IRQ_FLAG_OUT; endproperty
    a_dma: assert property (p_dma) else $error("request without flag");
    property p_step;
        !$stable(TIMEBASE_LOW_OUT) && !$past(wlo, 1) && !$past(wlo, 2) |->
            TIMEBASE_LOW_OUT == $past(TIMEBASE_LOW_OUT) + 16'h1 || TIMEBASE_LOW_OUT == 16'h0;
    endproperty
    a_step: assert property (p_step) else $error("time base jump");
    cover property ($rose(SINGLE_TIMER_IRQ_FLAG_OUT));
    cover property (ADC_TRIGGER_OUT);
    cover property (LOW_DMA_REQ_OUT);
endmodule : gp_timer_chk

bind gp_timer_set gp_timer_chk chk_u (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .SINGLE_TIMER_IRQ_FLAG_OUT(SINGLE_TIMER_IRQ_FLAG_OUT),
    .HIGH_TIMER_IRQ_FLAG_OUT(HIGH_TIMER_IRQ_FLAG_OUT),
    .LOW_TIMER_IRQ_FLAG_OUT(LOW_TIMER_IRQ_FLAG_OUT), .ADC_TRIGGER_OUT(ADC_TRIGGER_OUT),
    .LOW_DMA_REQ_OUT(LOW_DMA_REQ_OUT), .TIMEBASE_LOW_OUT(TIMEBASE_LOW_OUT));

//--- verification/ext_clock_src.sv
// Model of the external clock and gate pin sources
`timescale 1ns/1ns
module ext_clock_src (
    // Clock and control
    input wire logic clk_in,
    input wire logic [2:0] run_in,
    input wire logic [3:0] half_in,
    // Pins
    output logic [2:0] pin_out
);
    logic [3:0] cnt_reg;
    logic phase_reg;
    always_ff @(posedge clk_in) begin
        if (run_in == 3'h0) begin
            cnt_reg <= 4'h0;
            phase_reg <= 1'b0;
        end else if (cnt_reg == half_in) begin
            cnt_reg <= 4'h0;
            phase_reg <= ~phase_reg;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // Stopped pins sit low so only a running source gives edges
    assign pin_out = run_in & {3{phase_reg}};
endmodule : ext_clock_src

//--- verification/general_purpose_timer_set_test.sv
// Directed bench for the general purpose timer set
`timescale 1ns/1ns
module general_purpose_timer_set_test;
    import gp_timer_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, idle = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0, rdata, d, tb_lo, tb_hi;
    logic [2:0] pin_run = 3'h0, pins, flags;
    logic adc, dma_lo, dma_hi;
    int n_errors = 0, num_checks = 0, n_adc = 0, n_dma = 0, n_dmh = 0;
    int dv [4] = '{1, 8, 64, 256};
    always #5 clk = ~clk;
    gp_timer_set dut_u (.CLOCK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata), .IDLE_IN(idle),
        .SINGLE_TIMER_EXT_CLOCK_PIN_IN(pins[0]), .PAIR_EXT_CLOCK_PIN_IN(pins[1]),
        .HIGH_EXT_CLOCK_PIN_IN(pins[2]), .SINGLE_TIMER_IRQ_FLAG_OUT(flags[0]),
        .LOW_TIMER_IRQ_FLAG_OUT(flags[1]), .HIGH_TIMER_IRQ_FLAG_OUT(flags[2]),
        .ADC_TRIGGER_OUT(adc), .LOW_DMA_REQ_OUT(dma_lo), .HIGH_DMA_REQ_OUT(dma_hi),
        .TIMEBASE_LOW_OUT(tb_lo), .TIMEBASE_HIGH_OUT(tb_hi));
    ext_clock_src src_u (.clk_in(clk), .run_in(pin_run), .half_in(4'h3), .pin_out(pins));
    always @(posedge clk) begin
        n_adc <= n_adc + int'(adc);
        n_dma <= n_dma + int'(dma_lo);
        n_dmh <= n_dmh + int'(dma_hi);
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        if (got >= lo && got <= hi) chk(got, got);
        else chk(got, lo);
    endtask : rng
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(d, e);
    endtask : rdc
    task automatic wait_flag(input int i);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (flags[i] === 1'b1) break;
        end
        if (k == 300) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_flag
    // Clear the single count, run with ctl for n cycles, stop, read the count
    task automatic run1(input logic [15:0] ctl, input int n, input logic pin);
        wr(ADDR_SINGLE_COUNT, 16'h0);
        wr(ADDR_SINGLE_CONTROL, ctl);
        pin_run[0] <= pin;
        repeat (n) @(posedge clk);
        pin_run[0] <= 1'b0;
        wr(ADDR_SINGLE_CONTROL, 16'h0);
        rd(ADDR_SINGLE_COUNT);
    endtask : run1
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rdc(ADDR_SINGLE_CONTROL, CONTROL_RESET);
        rdc(ADDR_LOW_PERIOD, PERIOD_RESET);
        wr(ADDR_SINGLE_CONTROL, 16'h7fff);
        rdc(ADDR_SINGLE_CONTROL, 16'h2076);
        wr(ADDR_LOW_CONTROL, 16'h7fff);
        rdc(ADDR_LOW_CONTROL, 16'h207a);
        wr(ADDR_HIGH_CONTROL, 16'h7fff);
        rdc(ADDR_HIGH_CONTROL, 16'h2072);
        wr(4'hf, 16'h1234);
        rdc(4'hf, 16'h0000);
        wr(ADDR_SINGLE_PERIOD, 16'h0002);
        wr(ADDR_SINGLE_CONTROL, 16'h8000);
        wait_flag(0);
        rd(ADDR_SINGLE_COUNT);
        rng(d, 16'h0, 16'h2);
        wr(ADDR_SINGLE_CONTROL, 16'h0);
        wr(ADDR_FLAGS, 16'h0001);
        rdc(ADDR_FLAGS, 16'h0000);
        wr(ADDR_SINGLE_PERIOD, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            run1(16'h8000 | 16'(i << 4), 4 * dv[i] - 2, 1'b0);
            rng(d, 16'h3, 16'h5);
        end
        for (int j = 0; j < 2; j++) begin
            run1(16'h8002 | 16'(j << 2), 80, 1'b1);
            rng(d, 16'h8, 16'hb);
        end
        run1(16'h8040, 80, 1'b1);
        rng(d, 16'd34, 16'd44);
        rdc(ADDR_FLAGS, 16'h0001);
        run1(16'h8042, 80, 1'b1);
        rng(d, 16'h8, 16'hb);
        idle <= 1'b1;
        run1(16'ha000, 50, 1'b0);
        chk(d, 16'h0);
        run1(16'h8000, 50, 1'b0);
        rng(d, 16'd48, 16'd54);
        idle <= 1'b0;
        wr(ADDR_LOW_CONTROL, 16'h0008);
        wr(ADDR_HIGH_CONTROL, 16'h8030);
        wr(ADDR_LOW_COUNT, 16'hfffe);
        wr(ADDR_HIGH_COUNT, 16'h0000);
        wr(ADDR_LOW_PERIOD, 16'h0003);
        wr(ADDR_HIGH_PERIOD, 16'h0001);
        wr(ADDR_LOW_CONTROL, 16'h8008);
        wait_flag(2);
        wr(ADDR_LOW_CONTROL, 16'h0008);
        rdc(ADDR_FLAGS, 16'h0005);
        rdc(ADDR_HIGH_COUNT, 16'h0000);
        rd(ADDR_LOW_COUNT);
        chk(tb_lo, d);
        chk(tb_hi, 16'h0000);
        rng(16'(n_dmh), 16'h1, 16'h2);
        rng(16'(n_adc), 16'h1, 16'h2);
        wr(ADDR_FLAGS, 16'h0007);
        wr(ADDR_LOW_COUNT, 16'h0000);
        wr(ADDR_LOW_PERIOD, 16'h0002);
        wr(ADDR_LOW_CONTROL, 16'h8000);
        wait_flag(1);
        wr(ADDR_LOW_CONTROL, 16'h0000);
        rng(16'(n_dma), 16'h1, 16'h3);
        rdc(ADDR_FLAGS, 16'h0002);
        end_sim();
    end
endmodule : general_purpose_timer_set_test
